// *** inc/hpcf_pkg.sv ***
// hpcf_pkg: constants and carrier types shared by the hid packet channel framer
// assumes: one byte per report beat, reports are always sent at full size
package hpcf_pkg;

	// ==========================================================================
	// packet layout
	localparam int         PKT_BYTES      = 64;
	localparam int         INIT_HDR_BYTES = 7;
	localparam int         CONT_HDR_BYTES = 5;
	localparam int         SEQ_MAX        = 127;
	localparam int         POS_W          = 6;
	localparam logic [5:0] POS_CMD        = 6'd4;
	localparam logic [5:0] POS_LEN_HI     = 6'd5;
	localparam logic [5:0] POS_LEN_LO     = 6'd6;
	localparam logic [5:0] POS_INIT_DATA  = 6'(INIT_HDR_BYTES);
	localparam logic [5:0] POS_CONT_DATA  = 6'(CONT_HDR_BYTES);
	localparam logic [5:0] POS_LAST       = 6'(PKT_BYTES - 1);
	localparam int         TYPE_BIT       = 7;
	localparam logic [15:0] MAX_PAYLOAD   =
		16'(PKT_BYTES - INIT_HDR_BYTES + (SEQ_MAX + 1) * (PKT_BYTES - CONT_HDR_BYTES));

	// ==========================================================================
	// channel identifiers and error message
	localparam logic [31:0] CID_RESERVED  = 32'h0000_0000;
	localparam logic [31:0] CID_BROADCAST = 32'hFFFF_FFFF;
	localparam logic [31:0] CID_FIRST     = 32'h0000_0001;
	localparam logic [7:0]  ERR_CMD       = 8'hEE;
	localparam logic [7:0]  ERR_BUSY_CODE = 8'h01;
	localparam logic [15:0] ERR_LEN       = 16'h0001;

	// ==========================================================================
	// timing and storage
	localparam int TIMEOUT_MS  = 1000;
	localparam int CLK_KHZ     = 50_000;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	localparam int BUF_DEPTH   = 8192;

	// ==========================================================================
	// types
	typedef struct packed {
		logic [31:0] channel_ident;
		logic [7:0]  cmd;
		logic [15:0] len;
	} hpcf_msg_s;

	// gray order along idle, receive, wait, respond
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RX   = 2'b01,
		ST_WAIT = 2'b11,
		ST_RESP = 2'b10
	} hpcf_state_e;

	typedef enum logic [1:0] {
		MODE_DROP = 2'b00,
		MODE_INIT = 2'b01,
		MODE_CONT = 2'b11,
		MODE_BUSY = 2'b10
	} hpcf_mode_e;

endpackage

// *** hw/hpcf_buf.sv ***
// hpcf_buf: single-port-write, single-port-read message byte store
// assumes: read data is wanted one clock after the address
`timescale 1ns/1ps
`default_nettype none

module hpcf_buf #(
	parameter int W     = 8,
	parameter int DEPTH = 8192,
	parameter int AW    = $clog2(DEPTH)
)(
	input  wire logic          clock,
	input  wire logic          resetn,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);

	// ==========================================================================
	// storage
	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] rd_q;

	// array carries no reset, a flushed message is simply overwritten
	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// registered read so the output is a clean flop
	always_ff @(posedge clock)
	begin
		if (!resetn)
			rd_q <= '0;
		else
			rd_q <= mem[rd_addr];
	end

	assign rd_data = rd_q;

endmodule
`default_nettype wire

// *** hw/hpcf_framer.sv ***
// hpcf_framer: device side report framer, reassembles requests, frames responses
// assumes: rx beats are full reports, one byte a beat; core owns command meaning
`timescale 1ns/1ps
`default_nettype none

module hpcf_framer #(
	parameter int TIMEOUT_CYCLES = hpcf_pkg::TIMEOUT_CYC,
	parameter int BUF_DEPTH      = hpcf_pkg::BUF_DEPTH,
	parameter int AW             = $clog2(BUF_DEPTH),
	parameter int TW             = $clog2(TIMEOUT_CYCLES + 1)
)(
	input  wire logic                clock,
	input  wire logic                resetn,
	input  wire logic                rx_valid,
	input  wire logic [7:0]          rx_data,
	output logic                     tx_valid,
	output logic [7:0]               tx_data,
	output logic                     tx_last,
	input  wire logic                tx_ready,
	output logic                     req_valid,
	output hpcf_pkg::hpcf_msg_s      req_msg,
	output logic                     req_abort,
	input  wire logic [AW-1:0]       buf_rd_addr,
	output logic [7:0]               buf_rd_data,
	input  wire logic                buf_wr_en,
	input  wire logic [AW-1:0]       buf_wr_addr,
	input  wire logic [7:0]          buf_wr_data,
	input  wire logic                rsp_start,
	input  wire hpcf_pkg::hpcf_msg_s rsp_msg,
	output logic                     rsp_done,
	input  wire logic                alloc_req,
	output logic [31:0]              alloc_cid
);

	// ==========================================================================
	// declarations
	hpcf_pkg::hpcf_state_e state_q, state_d;
	hpcf_pkg::hpcf_mode_e  mode_q, mode_d;
	hpcf_pkg::hpcf_msg_s   act_q, act_d, rsp_q, rsp_d;
	logic [5:0]  rx_pos_q, rx_pos_d;
	logic [31:0] rx_cid_q, rx_cid_d, err_cid_q, err_cid_d, alloc_q, alloc_d;
	logic [15:0] rx_cnt_q, rx_cnt_d;
	logic [7:0]  exp_seq_q, exp_seq_d;
	logic [TW-1:0] timer_q, timer_d;
	logic        err_pend_q, err_pend_d, rsp_pend_q, rsp_pend_d;
	logic        req_valid_q, req_valid_d, abort_q, abort_d, done_q, done_d;
	logic        wr_en;
	logic [AW-1:0] wr_addr, rd_addr;
	logic [7:0]  wr_data, mem_q;
	logic        tx_act_q, tx_act_d, tx_err_q, tx_err_d, tx_fetch_q, tx_fetch_d;
	logic        tx_init_q, tx_init_d, tx_valid_q, tx_valid_d, tx_last_q, tx_last_d;
	logic [5:0]  tx_pos_q, tx_pos_d;
	logic [6:0]  tx_seq_q, tx_seq_d;
	logic [15:0] tx_cnt_q, tx_cnt_d;
	logic [7:0]  tx_data_q, tx_data_d;
	hpcf_pkg::hpcf_msg_s tx_msg_q, tx_msg_d;
	logic        tx_take_err, tx_take_rsp, tx_rsp_fin, tx_pay;
	logic        same_cid, is_init;

	assign same_cid = (rx_cid_q == act_q.channel_ident);
	assign is_init  = rx_data[hpcf_pkg::TYPE_BIT];

	// ==========================================================================
	// receive side and transaction state
	// decisions fall on the command byte, when the whole identifier is in
	always_comb
	begin
		state_d     = state_q;
		mode_d      = mode_q;
		act_d       = act_q;
		rsp_d       = rsp_q;
		rx_pos_d    = rx_pos_q;
		rx_cid_d    = rx_cid_q;
		rx_cnt_d    = rx_cnt_q;
		exp_seq_d   = exp_seq_q;
		timer_d     = timer_q;
		err_pend_d  = err_pend_q;
		err_cid_d   = err_cid_q;
		rsp_pend_d  = rsp_pend_q;
		abort_d     = 1'b0;
		done_d      = 1'b0;
		alloc_d     = alloc_q;
		wr_en       = 1'b0;
		wr_addr     = rx_cnt_q[AW-1:0];
		wr_data     = rx_data;
		// next identifier skips both reserved values
		if (alloc_req)
		begin
			alloc_d = alloc_q + 32'h0000_0001;
			if (alloc_d == hpcf_pkg::CID_RESERVED || alloc_d == hpcf_pkg::CID_BROADCAST)
				alloc_d = hpcf_pkg::CID_FIRST;
		end
		if (tx_take_err)
			err_pend_d = 1'b0;
		if (tx_take_rsp)
			rsp_pend_d = 1'b0;
		if (tx_rsp_fin)
		begin
			state_d = hpcf_pkg::ST_IDLE;
			done_d  = 1'b1;
		end
		// the timer covers the whole request, not each packet
		if (state_q == hpcf_pkg::ST_RX)
		begin
			timer_d = timer_q + TW'(1);
			if (timer_q == TW'(TIMEOUT_CYCLES - 1))
				state_d = hpcf_pkg::ST_IDLE;
		end
		// core may write its answer into the store while the request waits
		if (state_q == hpcf_pkg::ST_WAIT)
		begin
			wr_en   = buf_wr_en;
			wr_addr = buf_wr_addr;
			wr_data = buf_wr_data;
			if (rsp_start)
			begin
				rsp_d      = rsp_msg;
				rsp_d.channel_ident  = act_q.channel_ident;
				rsp_pend_d = 1'b1;
				state_d    = hpcf_pkg::ST_RESP;
			end
		end
		if (rx_valid)
		begin
			rx_pos_d = (rx_pos_q == hpcf_pkg::POS_LAST) ? 6'd0 : rx_pos_q + 6'd1;
			if (rx_pos_q < hpcf_pkg::POS_CMD)
				rx_cid_d = {rx_cid_q[23:0], rx_data};
			if (rx_pos_q == hpcf_pkg::POS_CMD)
			begin
				mode_d = hpcf_pkg::MODE_DROP;
				if (is_init && rx_cid_q != hpcf_pkg::CID_RESERVED)
				begin
					if (state_q == hpcf_pkg::ST_IDLE
						|| (same_cid && state_q != hpcf_pkg::ST_RESP))
					begin
						// a fresh init on the active channel restarts it, except in ST_RESP where it is dropped
						abort_d    = (state_q != hpcf_pkg::ST_IDLE);
						mode_d     = hpcf_pkg::MODE_INIT;
						state_d    = hpcf_pkg::ST_RX;
						act_d.channel_ident  = rx_cid_q;
						act_d.cmd  = rx_data;
						rx_cnt_d   = 16'h0000;
						exp_seq_d  = 8'h00;
						timer_d    = '0;
						rsp_pend_d = 1'b0;
					end
					else if (!same_cid && !err_pend_d)
					begin
						mode_d     = hpcf_pkg::MODE_BUSY;
						err_pend_d = 1'b1;
						err_cid_d  = rx_cid_q;
					end
				end
				else if (!is_init && state_q == hpcf_pkg::ST_RX && same_cid)
				begin
					// index 128 never matches, so a 129th continuation also drops
					if ({1'b0, rx_data[6:0]} == exp_seq_q)
					begin
						mode_d    = hpcf_pkg::MODE_CONT;
						exp_seq_d = exp_seq_q + 8'h01;
					end
					else
						state_d = hpcf_pkg::ST_IDLE;
				end
				// anything else is a stray continuation or noise
			end
			else if (mode_q == hpcf_pkg::MODE_INIT && rx_pos_q == hpcf_pkg::POS_LEN_HI)
				act_d.len[15:8] = rx_data;
			else if (mode_q == hpcf_pkg::MODE_INIT && rx_pos_q == hpcf_pkg::POS_LEN_LO)
				act_d.len[7:0] = rx_data;
			else if (state_q == hpcf_pkg::ST_RX && rx_cnt_q < act_q.len
				&& ((mode_q == hpcf_pkg::MODE_INIT && rx_pos_q >= hpcf_pkg::POS_INIT_DATA)
				|| (mode_q == hpcf_pkg::MODE_CONT && rx_pos_q >= hpcf_pkg::POS_CONT_DATA)))
			begin
				wr_en    = 1'b1;
				wr_addr  = rx_cnt_q[AW-1:0];
				wr_data  = rx_data;
				rx_cnt_d = rx_cnt_q + 16'h0001;
			end
			// message is judged once its packet has fully arrived
			if (rx_pos_q == hpcf_pkg::POS_LAST && state_d == hpcf_pkg::ST_RX
				&& (mode_q == hpcf_pkg::MODE_INIT || mode_q == hpcf_pkg::MODE_CONT))
			begin
				if (act_q.len > hpcf_pkg::MAX_PAYLOAD)
					state_d = hpcf_pkg::ST_IDLE;
				else if (rx_cnt_d >= act_q.len)
					state_d = hpcf_pkg::ST_WAIT;
			end
		end
		req_valid_d = (state_d == hpcf_pkg::ST_WAIT);
	end

	// register the receive group
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state_q     <= hpcf_pkg::ST_IDLE;
			mode_q      <= hpcf_pkg::MODE_DROP;
			act_q       <= '0;
			rsp_q       <= '0;
			rx_pos_q    <= '0;
			rx_cid_q    <= '0;
			rx_cnt_q    <= '0;
			exp_seq_q   <= '0;
			timer_q     <= '0;
			err_pend_q  <= 1'b0;
			err_cid_q   <= '0;
			rsp_pend_q  <= 1'b0;
			req_valid_q <= 1'b0;
			abort_q     <= 1'b0;
			done_q      <= 1'b0;
			alloc_q     <= hpcf_pkg::CID_FIRST;
		end
		else
		begin
			state_q     <= state_d;
			mode_q      <= mode_d;
			act_q       <= act_d;
			rsp_q       <= rsp_d;
			rx_pos_q    <= rx_pos_d;
			rx_cid_q    <= rx_cid_d;
			rx_cnt_q    <= rx_cnt_d;
			exp_seq_q   <= exp_seq_d;
			timer_q     <= timer_d;
			err_pend_q  <= err_pend_d;
			err_cid_q   <= err_cid_d;
			rsp_pend_q  <= rsp_pend_d;
			req_valid_q <= req_valid_d;
			abort_q     <= abort_d;
			done_q      <= done_d;
			alloc_q     <= alloc_d;
		end
	end

	// ==========================================================================
	// transmit side: a byte is fetched, shown, then handed off
	// three clocks a byte is slow but keeps the store single-ported
	assign rd_addr = (state_q == hpcf_pkg::ST_RESP) ? tx_cnt_q[AW-1:0] : buf_rd_addr;
	assign tx_pay  = tx_init_q ? (tx_pos_q >= hpcf_pkg::POS_INIT_DATA)
	                           : (tx_pos_q >= hpcf_pkg::POS_CONT_DATA);

	always_comb
	begin
		tx_act_d    = tx_act_q;
		tx_err_d    = tx_err_q;
		tx_fetch_d  = tx_fetch_q;
		tx_init_d   = tx_init_q;
		tx_valid_d  = tx_valid_q;
		tx_last_d   = tx_last_q;
		tx_pos_d    = tx_pos_q;
		tx_seq_d    = tx_seq_q;
		tx_cnt_d    = tx_cnt_q;
		tx_data_d   = tx_data_q;
		tx_msg_d    = tx_msg_q;
		tx_take_err = 1'b0;
		tx_take_rsp = 1'b0;
		tx_rsp_fin  = 1'b0;
		if (!tx_act_q)
		begin
			// busy errors go first, they are answers to someone waiting
			tx_take_err = err_pend_q;
			tx_take_rsp = !err_pend_q && rsp_pend_q;
			if (tx_take_err || tx_take_rsp)
			begin
				tx_act_d  = 1'b1;
				tx_err_d  = tx_take_err;
				tx_msg_d  = tx_take_err
					? hpcf_pkg::hpcf_msg_s'{channel_ident: err_cid_q, cmd: hpcf_pkg::ERR_CMD,
						len: hpcf_pkg::ERR_LEN}
					: rsp_q;
				tx_pos_d  = 6'd0;
				tx_init_d = 1'b1;
				tx_seq_d  = 7'd0;
				tx_cnt_d  = 16'h0000;
			end
		end
		else if (tx_fetch_q)
		begin
			tx_fetch_d = 1'b0;
			tx_valid_d = 1'b1;
			tx_last_d  = (tx_pos_q == hpcf_pkg::POS_LAST);
			tx_data_d  = 8'h00;
			if (tx_pos_q < hpcf_pkg::POS_CMD)
				tx_data_d = tx_msg_q.channel_ident[(5'd24 - {tx_pos_q[1:0], 3'b000}) +: 8];
			else if (tx_pos_q == hpcf_pkg::POS_CMD)
				tx_data_d = tx_init_q ? (tx_msg_q.cmd | 8'h80) : {1'b0, tx_seq_q};
			else if (tx_init_q && tx_pos_q == hpcf_pkg::POS_LEN_HI)
				tx_data_d = tx_msg_q.len[15:8];
			else if (tx_init_q && tx_pos_q == hpcf_pkg::POS_LEN_LO)
				tx_data_d = tx_msg_q.len[7:0];
			else if (tx_pay && tx_cnt_q < tx_msg_q.len)
				tx_data_d = tx_err_q ? hpcf_pkg::ERR_BUSY_CODE : mem_q;
		end
		else if (!tx_valid_q)
			tx_fetch_d = 1'b1;
		else if (tx_ready)
		begin
			tx_valid_d = 1'b0;
			if (tx_pay && tx_cnt_q < tx_msg_q.len)
				tx_cnt_d = tx_cnt_q + 16'h0001;
			tx_pos_d = tx_pos_q + 6'd1;
			if (tx_last_q)
			begin
				tx_pos_d  = 6'd0;
				tx_init_d = 1'b0;
				tx_seq_d  = tx_init_q ? 7'd0 : tx_seq_q + 7'd1;
				if (tx_cnt_d >= tx_msg_q.len)
				begin
					tx_act_d   = 1'b0;
					tx_rsp_fin = !tx_err_q;
				end
			end
		end
	end

	// register the transmit group
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			tx_act_q   <= 1'b0;
			tx_err_q   <= 1'b0;
			tx_fetch_q <= 1'b0;
			tx_init_q  <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_last_q  <= 1'b0;
			tx_pos_q   <= '0;
			tx_seq_q   <= '0;
			tx_cnt_q   <= '0;
			tx_data_q  <= '0;
			tx_msg_q   <= '0;
		end
		else
		begin
			tx_act_q   <= tx_act_d;
			tx_err_q   <= tx_err_d;
			tx_fetch_q <= tx_fetch_d;
			tx_init_q  <= tx_init_d;
			tx_valid_q <= tx_valid_d;
			tx_last_q  <= tx_last_d;
			tx_pos_q   <= tx_pos_d;
			tx_seq_q   <= tx_seq_d;
			tx_cnt_q   <= tx_cnt_d;
			tx_data_q  <= tx_data_d;
			tx_msg_q   <= tx_msg_d;
		end
	end

	// ==========================================================================
	// message store and outputs
	hpcf_buf #(.W(8), .DEPTH(BUF_DEPTH), .AW(AW)) u_buf (
		.clock   (clock),
		.resetn  (resetn),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (rd_addr),
		.rd_data (mem_q)
	);

	assign tx_valid    = tx_valid_q;
	assign tx_data     = tx_data_q;
	assign tx_last     = tx_last_q;
	assign req_valid   = req_valid_q;
	assign req_msg     = act_q;
	assign req_abort   = abort_q;
	assign buf_rd_data = mem_q;
	assign rsp_done    = done_q;
	assign alloc_cid   = alloc_q;

	// ==========================================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	init_cmd_bit_a: assert property (
		tx_valid_q && tx_init_q && tx_pos_q == hpcf_pkg::POS_CMD |-> tx_data_q[7])
		else $error("init command byte without bit 7");
	cont_index_a: assert property (
		tx_valid_q && !tx_init_q && tx_pos_q == hpcf_pkg::POS_CMD
		|-> tx_data_q == {1'b0, tx_seq_q})
		else $error("continuation index byte wrong");
	pad_zero_a: assert property (
		tx_valid_q && tx_pay && tx_cnt_q >= tx_msg_q.len |-> tx_data_q == 8'h00)
		else $error("padding byte not zero");
	pkt_end_a: assert property (
		tx_valid_q && tx_last_q |-> tx_pos_q == hpcf_pkg::POS_LAST)
		else $error("packet end at wrong byte");
	rsp_after_req_a: assert property (
		tx_valid_q && !tx_err_q |-> state_q == hpcf_pkg::ST_RESP)
		else $error("response sent outside a transaction");
	busy_err_a: assert property (
		rx_valid && rx_pos_q == hpcf_pkg::POS_CMD && is_init && !same_cid
		&& state_q != hpcf_pkg::ST_IDLE && state_q != hpcf_pkg::ST_RESP && !tx_act_q
		&& !err_pend_q && rx_cid_q != 32'h0000_0000
		|=> err_pend_q && err_cid_q == $past(rx_cid_q) ##[0:1] tx_take_err)
		else $error("busy error not queued");
	stray_cont_a: assert property (
		rx_valid && rx_pos_q == hpcf_pkg::POS_CMD && !is_init && state_q != hpcf_pkg::ST_RX
		|=> mode_q == hpcf_pkg::MODE_DROP)
		else $error("stray continuation accepted");
	seq_abort_a: assert property (
		rx_valid && rx_pos_q == hpcf_pkg::POS_CMD && !is_init && same_cid
		&& state_q == hpcf_pkg::ST_RX && {1'b0, rx_data[6:0]} != exp_seq_q
		|=> state_q == hpcf_pkg::ST_IDLE && !req_valid_q)
		else $error("bad index did not drop message");
	resync_a: assert property (
		rx_valid && rx_pos_q == hpcf_pkg::POS_CMD && is_init && same_cid
		&& state_q == hpcf_pkg::ST_WAIT && rx_cid_q != 32'h0000_0000
		|=> req_abort && state_q == hpcf_pkg::ST_RX && rx_cnt_q == 16'h0000)
		else $error("init on active channel did not restart");
	timeout_a: assert property (
		state_q == hpcf_pkg::ST_RX && timer_q == TW'(TIMEOUT_CYCLES - 1)
		&& !(rx_valid && rx_pos_q == hpcf_pkg::POS_CMD) |=> state_q == hpcf_pkg::ST_IDLE)
		else $error("stalled request not dropped");
	alloc_ok_a: assert property (
		$rose(alloc_req) |=> alloc_cid != 32'h0000_0000 && alloc_cid != 32'hFFFF_FFFF)
		else $error("reserved identifier allocated");

endmodule
`default_nettype wire

// *** tb/hpcf_host.sv ***
// hpcf_host: host application model, sends out reports and sinks in reports
// assumes: 64 byte reports, one byte a beat, drives 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none

module hpcf_host (
	input  wire logic       clock,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] pkt [64];
	logic [7:0] rxq [$];
	logic       busy;

	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
		tx_ready = 1'b0;
		busy = 1'b0;
	end

	// ==========================================================================
	// out report: always the full 64 beats, padding already zero in pkt
	task automatic send();
		busy = 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clock);
			#1;
			rx_valid = 1'b1;
			rx_data = pkt[i];
		end
		@(posedge clock);
		#1;
		rx_valid = 1'b0;
		busy = 1'b0;
	endtask

	// idle data toggles so a stale byte never looks valid by luck
	always @(posedge clock)
	begin
		#1;
		if (!busy)
			rx_data = ~rx_data;
	end

	// in report sink with random stalls, as a slow hid stack would
	always @(posedge clock)
	begin
		if (tx_valid && tx_ready)
			rxq.push_back(tx_data);
		#1;
		tx_ready = ($urandom_range(0, 3) != 0);
	end
endmodule
`default_nettype wire

// *** tb/hpcf_framer_test.sv ***
// hpcf_framer_test: self-checking bench for the report framer
// assumes: host model on the report side, bench plays the core side
`timescale 1ns/1ps
`default_nettype none

module hpcf_framer_test;
	localparam int AW = $clog2(hpcf_pkg::BUF_DEPTH);
	logic clock, resetn, rx_valid, tx_valid, tx_last, tx_ready, req_valid, req_abort;
	logic buf_wr_en, rsp_start, rsp_done, alloc_req;
	logic [7:0] rx_data, tx_data, buf_rd_data, buf_wr_data;
	logic [AW-1:0] buf_rd_addr, buf_wr_addr;
	logic [31:0] alloc_cid, ca, cb;
	hpcf_pkg::hpcf_msg_s req_msg, rsp_msg;
	logic [7:0] pay [256];
	int miscompares, num_checks, rxbase, dones, ndone, aborts, lasts, cyc, a0;

	hpcf_framer #(.TIMEOUT_CYCLES(200)) i_dut (.clock(clock), .resetn(resetn),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(tx_ready), .req_valid(req_valid), .req_msg(req_msg),
		.req_abort(req_abort), .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data),
		.buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data),
		.rsp_start(rsp_start), .rsp_msg(rsp_msg), .rsp_done(rsp_done),
		.alloc_req(alloc_req), .alloc_cid(alloc_cid));

	hpcf_host i_host (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	// ==========================================================================
	// clock, pulse counters and hang guard
	initial
		clock = 1'b0;
	always #10 clock = ~clock;

	always @(posedge clock)
	begin
		cyc++;
		dones += (rsp_done === 1'b1);
		aborts += (req_abort === 1'b1);
		lasts += (tx_valid && tx_ready && tx_last === 1'b1);
		if (cyc == 40000)
		begin
			miscompares++;
			test_done();
		end
	end

	// ==========================================================================
	// checking helpers
	task automatic check(logic [63:0] seen, logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic int npkt(int len);
		return (len <= 57) ? 1 : 2 + (len - 58) / 59;
	endfunction

	// expected byte i of packet p of a message, padding zero
	function automatic logic [7:0] fbyte(logic [31:0] channel_ident, logic [7:0] cmd,
		logic [15:0] len, int p, int i);
		int off;
		if (i < 4)
			return channel_ident[31 - 8 * i -: 8];
		if (p == 0)
		begin
			if (i == 4)
				return cmd;
			if (i == 5)
				return len[15:8];
			if (i == 6)
				return len[7:0];
			off = i - 7;
		end
		else
		begin
			if (i == 4)
				return 8'(p - 1);
			off = 57 + (p - 1) * 59 + i - 5;
		end
		return (off < len) ? pay[off] : 8'h00;
	endfunction

	// ==========================================================================
	// transfer tasks
	task automatic send_pkt(logic [31:0] channel_ident, logic [7:0] cmd, logic [15:0] len, int p);
		for (int i = 0; i < 64; i++)
			i_host.pkt[i] = fbyte(channel_ident, cmd, len, p, i);
		i_host.send();
	endtask

	task automatic no_req();
		repeat (5) @(posedge clock);
		#1;
		check(req_valid, 1'b0);
	endtask

	task automatic request(logic [31:0] channel_ident, logic [7:0] cmd, logic [15:0] len);
		for (int k = 0; k < 256; k++)
			pay[k] = 8'($urandom);
		for (int p = 0; p < npkt(len); p++)
			send_pkt(channel_ident, cmd, len, p);
		for (int n = 0; n < 10 && req_valid !== 1'b1; n++)
			@(posedge clock);
		#1;
		check(req_valid, 1'b1);
		check(req_msg, {channel_ident, cmd, len});
		for (int k = 0; k < len; k++)
		begin
			buf_rd_addr = AW'(k);
			repeat (2) @(posedge clock);
			#1;
			check(buf_rd_data, pay[k]);
		end
	endtask

	task automatic frames(logic [31:0] channel_ident, logic [7:0] cmd, logic [15:0] len);
		for (int w = 0; w < 4000 && i_host.rxq.size() < rxbase + 64 * npkt(len); w++)
			@(posedge clock);
		#1;
		for (int p = 0; p < npkt(len); p++)
			for (int i = 0; i < 64; i++)
				check(i_host.rxq[rxbase + 64 * p + i], fbyte(channel_ident, cmd, len, p, i));
		rxbase += 64 * npkt(len);
	endtask

	// core writes payload, starts response with a wrong cid to be replaced
	task automatic respond(logic [31:0] channel_ident, logic [7:0] cmd, logic [15:0] len);
		for (int k = 0; k < len; k++)
		begin
			pay[k] = 8'($urandom);
			@(posedge clock);
			#1;
			buf_wr_en = 1'b1;
			buf_wr_addr = AW'(k);
			buf_wr_data = pay[k];
		end
		@(posedge clock);
		#1;
		buf_wr_en = 1'b0;
		rsp_start = 1'b1;
		rsp_msg = '{channel_ident: ~channel_ident, cmd: cmd, len: len};
		@(posedge clock);
		#1;
		rsp_start = 1'b0;
		frames(channel_ident, cmd, len);
		repeat (4) @(posedge clock);
		#1;
		ndone++;
		check(dones, ndone);
		check(req_valid, 1'b0);
	endtask

	// ==========================================================================
	// main sequence
	initial
	begin
		void'($urandom(51685));
		{resetn, buf_wr_en, rsp_start, alloc_req} = '0;
		{buf_rd_addr, buf_wr_addr, buf_wr_data, rsp_msg} = '0;
		ca = {4'h1, 28'($urandom)};
		cb = {4'h2, 28'($urandom)};
		repeat (5) @(posedge clock);
		#1;
		resetn = 1'b1;
		check(alloc_cid, 32'h0000_0001);
		alloc_req = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		alloc_req = 1'b0;
		@(posedge clock);
		#1;
		check(alloc_cid, 32'h0000_0004);
		// response without request, then stray continuation
		rsp_start = 1'b1;
		@(posedge clock);
		#1;
		rsp_start = 1'b0;
		repeat (20) @(posedge clock);
		check(i_host.rxq.size(), 0);
		send_pkt(ca, 8'h00, 16'd100, 1);
		no_req();
		// length corners for requests and responses
		request(ca, 8'h80 | 8'($urandom), 16'd57);
		respond(ca, 8'h81, 16'd117);
		request(ca, 8'h80 | 8'($urandom), 16'd58 + 16'($urandom_range(0, 190)));
		respond(ca, 8'hC3, 16'd57);
		request(cb, 8'h80 | 8'($urandom), 16'd0);
		respond(cb, 8'h90, 16'd116);
		// other channel while busy gets the busy error
		request(ca, 8'h86, 16'd20);
		send_pkt(cb, 8'h90, 16'd5, 0);
		pay[0] = hpcf_pkg::ERR_BUSY_CODE;
		frames(cb, hpcf_pkg::ERR_CMD, hpcf_pkg::ERR_LEN);
		check(req_msg, {ca, 8'h86, 16'd20});
		respond(ca, 8'h86, 16'd3);
		// wrong index drops the message, later pieces are strays
		send_pkt(ca, 8'h88, 16'd150, 0);
		send_pkt(ca, 8'h88, 16'd150, 2);
		send_pkt(ca, 8'h88, 16'd150, 1);
		send_pkt(ca, 8'h88, 16'd150, 2);
		no_req();
		// stalled request times out
		send_pkt(ca, 8'h88, 16'd100, 0);
		repeat (300) @(posedge clock);
		send_pkt(ca, 8'h88, 16'd100, 1);
		no_req();
		// init on the active channel restarts the request
		send_pkt(ca, 8'h88, 16'd150, 0);
		a0 = aborts;
		request(ca, 8'hA1, 16'd30);
		check(aborts, a0 + 1);
		respond(ca, 8'hA1, 16'd10);
		check(lasts, rxbase / 64);
		test_done();
	end
endmodule
`default_nettype wire
